// file: hw/slhcp_pkg.sv
package slhcp_pkg;

   // ----------------------------------------------------------------
   // host register layout
   // ----------------------------------------------------------------
   localparam int BUS_W = 32;
   localparam int CMD_W = 16;
   localparam int DATA_W = 8;
   localparam int MASK_W = 8;
   localparam int REG_IDX_W = 1;
   localparam logic [REG_IDX_W-1:0] REG_CMD_IDX = 1'h0;
   localparam logic [REG_IDX_W-1:0] REG_DATA_IDX = 1'h1;

   // ----------------------------------------------------------------
   // command word fields
   // ----------------------------------------------------------------
   localparam int BIT_IGNORE = 31;
   localparam int BIT_WRITE = 15;
   localparam int BIT_PROC = 14;
   localparam int BIT_REQ = 13;
   localparam int BIT_SYNC = 12;
   localparam int BIT_STARTSTOP = 11;
   localparam int TYPE_LSB = 8;
   localparam int TYPE_W = 3;
   localparam int PARAM_ADDR_W = 8;
   localparam logic [TYPE_W-1:0] TYPE_STOP = 3'h0;
   localparam logic [TYPE_W-1:0] TYPE_START = 3'h1;
   localparam logic [TYPE_W-1:0] TYPE_SETUP = 3'h7;
   localparam logic [CMD_W-1:0] CMD_IDLE = 16'h0000;
   localparam logic [CMD_W-1:0] CMD_STOP_EVERY_CHANNEL = 16'h0800;
   localparam logic [7:0] CMD_START_HIGH = 8'h09;

   // ----------------------------------------------------------------
   // reset values and local parameter table
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;
   localparam logic [PARAM_ADDR_W-1:0] LOCAL_CNT = 8'h08;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PROC_RESET_NS = 100;
   localparam int PROC_RESET_CYC = (PROC_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      KIND_SYNC = 2'b00,
      KIND_START = 2'b01,
      KIND_STOP = 2'b10,
      KIND_SETUP = 2'b11
   } slhcp_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LOOKUP = 3'b001,
      ST_CHAN = 3'b010,
      ST_PRESET = 3'b011,
      ST_FINISH = 3'b100
   } slhcp_state_t;

endpackage : slhcp_pkg

// file: hw/slhcp_param_mem.sv
`timescale 1ns/1ps
module slhcp_param_mem #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic wrEn,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData
);

   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // array has no reset: contents are whatever software stored last
   always_ff @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read, one cycle behind the address
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdData <= '0;
      end else begin
         rdData <= mem[rdAddr];
      end
   end

endmodule : slhcp_param_mem

// file: hw/slhcp_command_port.sv
`timescale 1ns/1ps
module slhcp_command_port #(
   parameter logic [7:0] ID_IFACE_TYPE = 8'h5A, // arbitrary value
   parameter logic [7:0] ID_MAJOR_REV = 8'h01, // arbitrary value
   parameter logic [7:0] ID_MINOR_REV = 8'h00, // arbitrary value
   parameter logic [7:0] ID_PROC_TYPE = 8'hA5, // arbitrary value
   parameter logic [7:0] CHANNEL_COUNT = 8'h08
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [slhcp_pkg::REG_IDX_W-1:0] regIdx,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [slhcp_pkg::BUS_W-1:0] regWrData,
   output logic [slhcp_pkg::BUS_W-1:0] regRdData,
   output logic chanReq,
   output slhcp_pkg::slhcp_kind_t chanKind,
   output logic [slhcp_pkg::MASK_W-1:0] chanMask,
   input wire logic chanDone,
   input wire logic [slhcp_pkg::MASK_W-1:0] chanStatus,
   output logic stop_every_channel_command,
   output logic procReset,
   output logic [slhcp_pkg::MASK_W-1:0] activeMask
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   slhcp_pkg::slhcp_state_t state_q;
   slhcp_pkg::slhcp_state_t state_d;
   logic [slhcp_pkg::CMD_W-1:0] cmd_q;
   logic [slhcp_pkg::DATA_W-1:0] data_q;
   logic [slhcp_pkg::CNT_W-1:0] cnt_q;
   logic [slhcp_pkg::DATA_W-1:0] memRdData;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   logic wrCmd;
   logic isStopAll;
   logic accept;
   logic [slhcp_pkg::CMD_W-1:0] newCmd;
   logic [slhcp_pkg::PARAM_ADDR_W-1:0] newAddr;
   logic [slhcp_pkg::TYPE_W-1:0] newType;
   logic isLocal;
   logic isLocalRd;
   logic isLocalWr;
   logic isChanCmd;
   logic memWe;

   assign newCmd = regWrData[slhcp_pkg::CMD_W-1:0];
   assign newAddr = regWrData[slhcp_pkg::PARAM_ADDR_W-1:0];
   assign newType = regWrData[slhcp_pkg::TYPE_LSB +: slhcp_pkg::TYPE_W];
   // bit 31 writes never reach the command logic
   assign wrCmd = regWr && (regIdx == slhcp_pkg::REG_CMD_IDX)
                  && !regWrData[slhcp_pkg::BIT_IGNORE];
   assign isStopAll = wrCmd && (newCmd == slhcp_pkg::CMD_STOP_EVERY_CHANNEL);
   // busy writes other than stop-all are dropped so the readback keeps the old command
   assign accept = wrCmd && !isStopAll && (state_q == slhcp_pkg::ST_IDLE)
                   && (cmd_q == slhcp_pkg::CMD_IDLE)
                   && (newCmd != slhcp_pkg::CMD_IDLE);
   assign isLocal = !regWrData[slhcp_pkg::BIT_PROC] && regWrData[slhcp_pkg::BIT_REQ];
   assign isLocalWr = isLocal && regWrData[slhcp_pkg::BIT_WRITE];
   assign isLocalRd = isLocal && !regWrData[slhcp_pkg::BIT_WRITE];
   assign isChanCmd = !regWrData[slhcp_pkg::BIT_PROC] && !regWrData[slhcp_pkg::BIT_REQ]
                      && (regWrData[slhcp_pkg::BIT_SYNC]
                          || (regWrData[slhcp_pkg::BIT_STARTSTOP]
                              && (newType == slhcp_pkg::TYPE_STOP
                                  || newType == slhcp_pkg::TYPE_START
                                  || newType == slhcp_pkg::TYPE_SETUP)));
   // the first locals are fixed, writes to them are quietly dropped
   assign memWe = accept && isLocalWr && (newAddr >= slhcp_pkg::LOCAL_CNT);

   // fixed local parameter table
   function automatic logic [7:0] localVal(input logic [2:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         3'h0: v = ID_IFACE_TYPE;
         3'h1: v = 8'h08;
         3'h2: v = ID_MAJOR_REV;
         3'h3: v = ID_MINOR_REV;
         3'h6: v = ID_PROC_TYPE;
         3'h7: v = CHANNEL_COUNT;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : localVal

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   // next state: stop-all overrides anything in flight
   always_comb begin
      state_d = state_q;
      case (state_q)
         slhcp_pkg::ST_IDLE: begin
            if (accept) begin
               if (regWrData[slhcp_pkg::BIT_PROC]) begin
                  state_d = slhcp_pkg::ST_PRESET;
               end else if (isLocalRd && newAddr >= slhcp_pkg::LOCAL_CNT) begin
                  state_d = slhcp_pkg::ST_LOOKUP;
               end else if (isChanCmd) begin
                  state_d = slhcp_pkg::ST_CHAN;
               end else begin
                  state_d = slhcp_pkg::ST_FINISH;
               end
            end
         end
         slhcp_pkg::ST_LOOKUP: state_d = slhcp_pkg::ST_FINISH;
         slhcp_pkg::ST_CHAN: begin
            if (chanDone) begin
               state_d = slhcp_pkg::ST_FINISH;
            end
         end
         slhcp_pkg::ST_PRESET: begin
            if (cnt_q == '0) begin
               state_d = slhcp_pkg::ST_FINISH;
            end
         end
         slhcp_pkg::ST_FINISH: state_d = slhcp_pkg::ST_IDLE;
         default: state_d = slhcp_pkg::ST_IDLE;
      endcase
      if (isStopAll) begin
         state_d = slhcp_pkg::ST_FINISH;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q <= slhcp_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // command word: stop-all first, then completion, then a fresh command
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cmd_q <= slhcp_pkg::CMD_IDLE;
      end else if (isStopAll) begin
         cmd_q <= slhcp_pkg::CMD_STOP_EVERY_CHANNEL;
      end else if (state_q == slhcp_pkg::ST_FINISH) begin
         cmd_q <= slhcp_pkg::CMD_IDLE;
      end else if (accept) begin
         cmd_q <= newCmd;
      end
   end

   // processor reset hold time
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_q <= '0;
         procReset <= 1'b0;
      end else begin
         procReset <= (state_d == slhcp_pkg::ST_PRESET);
         if (state_q == slhcp_pkg::ST_IDLE) begin
            cnt_q <= slhcp_pkg::CNT_W'(slhcp_pkg::PROC_RESET_CYC - 1);
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // data register
   // ----------------------------------------------------------------
   // hardware results win over a host write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         data_q <= slhcp_pkg::DATA_RESET;
      end else if (state_q == slhcp_pkg::ST_LOOKUP) begin
         data_q <= memRdData;
      end else if (state_q == slhcp_pkg::ST_CHAN && chanDone) begin
         data_q <= chanStatus;
      end else if (accept && isLocalRd && newAddr < slhcp_pkg::LOCAL_CNT) begin
         data_q <= localVal(newAddr[2:0]);
      end else if (regWr && regIdx == slhcp_pkg::REG_DATA_IDX) begin
         data_q <= regWrData[slhcp_pkg::DATA_W-1:0];
      end
   end

   // writable locals live in a small memory, filled from the data byte
   slhcp_param_mem #(
      .ADDR_W(slhcp_pkg::PARAM_ADDR_W),
      .DATA_W(slhcp_pkg::DATA_W)
   ) u_mem (
      .sys_clk(sys_clk),
      .srst(srst),
      .wrEn(memWe),
      .wrAddr(newAddr),
      .wrData(data_q),
      .rdAddr(newAddr),
      .rdData(memRdData)
   );

   // ----------------------------------------------------------------
   // channel request
   // ----------------------------------------------------------------
   // request held as a level until the channel side answers or a stop-all drops it
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         chanReq <= 1'b0;
         chanKind <= slhcp_pkg::KIND_SYNC;
         chanMask <= slhcp_pkg::MASK_RESET;
      end else if (isStopAll) begin
         chanReq <= 1'b0;
      end else if (accept && isChanCmd) begin
         chanReq <= 1'b1;
         chanMask <= regWrData[slhcp_pkg::MASK_W-1:0];
         if (regWrData[slhcp_pkg::BIT_SYNC]) begin
            chanKind <= slhcp_pkg::KIND_SYNC;
         end else if (newType == slhcp_pkg::TYPE_START) begin
            chanKind <= slhcp_pkg::KIND_START;
         end else if (newType == slhcp_pkg::TYPE_SETUP) begin
            chanKind <= slhcp_pkg::KIND_SETUP;
         end else begin
            chanKind <= slhcp_pkg::KIND_STOP;
         end
      end else if (chanDone) begin
         chanReq <= 1'b0;
      end
   end

   // started channels: status bits mark the ones that failed
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         activeMask <= slhcp_pkg::MASK_RESET;
         stop_every_channel_command <= 1'b0;
      end else begin
         stop_every_channel_command <= isStopAll;
         if (isStopAll) begin
            activeMask <= slhcp_pkg::MASK_RESET;
         end else if (state_q == slhcp_pkg::ST_CHAN && chanDone) begin
            if (chanKind == slhcp_pkg::KIND_START || chanKind == slhcp_pkg::KIND_SETUP) begin
               activeMask <= activeMask | (chanMask & ~chanStatus);
            end else if (chanKind == slhcp_pkg::KIND_STOP) begin
               activeMask <= activeMask & ~chanMask;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // one cycle of read latency; upper bits read as zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regRdData <= '0;
      end else if (regRd) begin
         if (regIdx == slhcp_pkg::REG_CMD_IDX) begin
            regRdData <= {16'h0000, cmd_q};
         end else begin
            regRdData <= {24'h000000, data_q};
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   localparam int PresetMax = slhcp_pkg::PROC_RESET_CYC + 2;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   a_ignore_bit_31: assert property (
      (regWr && regIdx == slhcp_pkg::REG_CMD_IDX && regWrData[slhcp_pkg::BIT_IGNORE]
       && state_q == slhcp_pkg::ST_IDLE && cmd_q == slhcp_pkg::CMD_IDLE)
      |=> (cmd_q == slhcp_pkg::CMD_IDLE && state_q == slhcp_pkg::ST_IDLE))
      else $error("ignored command write changed state");

   a_cmd_start: assert property (
      accept |=> (state_q != slhcp_pkg::ST_IDLE && cmd_q == $past(newCmd)))
      else $error("command not taken on write");

   a_done_clear: assert property (
      (state_q == slhcp_pkg::ST_FINISH && !isStopAll) |=> cmd_q == slhcp_pkg::CMD_IDLE)
      else $error("command word not cleared at completion");

   a_busy_hold: assert property (
      ((state_q == slhcp_pkg::ST_CHAN || state_q == slhcp_pkg::ST_PRESET
        || state_q == slhcp_pkg::ST_LOOKUP) && !isStopAll) |=> $stable(cmd_q))
      else $error("command word changed while busy");

   a_stop_any: assert property (
      isStopAll |=> (cmd_q == slhcp_pkg::CMD_STOP_EVERY_CHANNEL
                     && state_q == slhcp_pkg::ST_FINISH && !chanReq && stop_every_channel_command))
      else $error("stop-all not taken");

   a_stop_clears: assert property (
      isStopAll |=> activeMask == slhcp_pkg::MASK_RESET)
      else $error("stop-all left channels active");

   a_preset_len: assert property (
      (accept && regWrData[slhcp_pkg::BIT_PROC])
      |=> ((procReset[*8] ##[1:PresetMax] (state_q == slhcp_pkg::ST_FINISH))
           or (##[1:8] isStopAll)))
      else $error("processor reset too short or never ends");

   a_local_read: assert property (
      (accept && isLocalRd && newAddr < slhcp_pkg::LOCAL_CNT)
      |=> (data_q == localVal($past(newAddr[2:0])) ##1 cmd_q == slhcp_pkg::CMD_IDLE)
          or ##[0:1] isStopAll)
      else $error("local read result wrong");

   a_sync_mask: assert property (
      (accept && regWrData[slhcp_pkg::BIT_SYNC] && isChanCmd)
      |=> (chanReq && chanKind == slhcp_pkg::KIND_SYNC && chanMask == $past(newAddr)))
      else $error("sync transfer request wrong");

   a_start_code: assert property (
      (accept && newCmd[15:8] == slhcp_pkg::CMD_START_HIGH)
      |=> (chanReq && chanKind == slhcp_pkg::KIND_START))
      else $error("start command not decoded");

   a_chan_status: assert property (
      (state_q == slhcp_pkg::ST_CHAN && chanDone && !isStopAll)
      |=> (data_q == $past(chanStatus) && !chanReq))
      else $error("channel status not captured");

   c_stop_busy: cover property (state_q == slhcp_pkg::ST_CHAN && isStopAll);
   c_mem_read: cover property (state_q == slhcp_pkg::ST_LOOKUP ##2 cmd_q == slhcp_pkg::CMD_IDLE);
   c_sync_done: cover property (chanReq && chanKind == slhcp_pkg::KIND_SYNC && chanDone);
   c_proc_reset: cover property ($fell(procReset));

endmodule : slhcp_command_port

// file: tb/serial_link_host_command_port_tb_top.sv
`timescale 1ns/1ps
// one compare, counted; a mismatch is printed at once
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("FAIL %s expected %h seen %h", nm, exp, got); end end

module serial_link_host_command_port_tb_top;

   // ----------------------------------------------------------------
   // signals and bench model state
   // ----------------------------------------------------------------
   localparam logic [7:0] CHAN_CNT = 8'h06;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [slhcp_pkg::REG_IDX_W-1:0] regIdx = '0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regWrData = '0;
   logic [31:0] regRdData;
   logic chanReq;
   slhcp_pkg::slhcp_kind_t chanKind;
   logic [7:0] chanMask;
   logic chanDone = 1'b0;
   logic [7:0] chanStatus = '0;
   logic stop_every_channel_command;
   logic procReset;
   logic [7:0] activeMask;
   int n_errors = 0;
   int num_checks = 0;
   int seed = 32'h1acc65a1;
   int stopSeen = 0;
   logic [31:0] rv;
   logic [7:0] mdlMem [int]; // writable parameters as the host left them
   logic [7:0] mdlData = 8'h00;
   logic [7:0] mdlAct = 8'h00; // channels the model believes started
   logic [7:0] hiTab [4] = '{8'h09, 8'h10, 8'h08, 8'h0F};
   slhcp_pkg::slhcp_kind_t kindTab [4] = '{slhcp_pkg::KIND_START, slhcp_pkg::KIND_SYNC,
      slhcp_pkg::KIND_STOP, slhcp_pkg::KIND_SETUP};

   slhcp_command_port #(.CHANNEL_COUNT(CHAN_CNT)) slhcp_command_port_inst (
      .sys_clk(sys_clk),
      .srst(srst),
      .regIdx(regIdx),
      .regWr(regWr),
      .regRd(regRd),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .chanReq(chanReq),
      .chanKind(chanKind),
      .chanMask(chanMask),
      .chanDone(chanDone),
      .chanStatus(chanStatus),
      .stop_every_channel_command(stop_every_channel_command),
      .procReset(procReset),
      .activeMask(activeMask)
   );

   // clock, 4 ns period
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   // stop pulses are one cycle wide, so count them rather than sample them
   always @(posedge sys_clk) begin
      if (stop_every_channel_command === 1'b1) stopSeen++;
   end

   // ----------------------------------------------------------------
   // register bus tasks, driven at the falling edge
   // ----------------------------------------------------------------
   task automatic wr(input logic idx, input logic [31:0] d);
      @(negedge sys_clk);
      regIdx = idx;
      regWrData = d;
      regWr = 1'b1;
      @(negedge sys_clk);
      regWr = 1'b0;
      regWrData = $random(seed); // bus data is meaningless between writes
   endtask : wr

   task automatic rd(input logic idx, output logic [31:0] v);
      @(negedge sys_clk);
      regIdx = idx;
      regRd = 1'b1;
      @(negedge sys_clk);
      regRd = 1'b0;
      v = regRdData;
   endtask : rd

   // host side of the handshake: poll until the word reads zero
   task automatic wait_idle();
      int n;
      for (n = 0; n < 200; n++) begin
         rd(slhcp_pkg::REG_CMD_IDX, rv);
         if (rv === 32'h0) break;
      end
      `CHK("cmd cleared", 32'h0, rv)
   endtask : wait_idle

   task automatic loc_rd(input logic [7:0] addr, input logic [7:0] exp);
      wait_idle();
      wr(slhcp_pkg::REG_CMD_IDX, 32'h2000 | addr);
      wait_idle();
      rd(slhcp_pkg::REG_DATA_IDX, rv);
      mdlData = exp;
      `CHK("local read", {24'h0, exp}, rv)
   endtask : loc_rd

   task automatic wait_req();
      int n;
      for (n = 0; n < 4 && chanReq !== 1'b1; n++) @(negedge sys_clk);
      `CHK("chanReq", 1'b1, chanReq)
   endtask : wait_req

   // one channel command, answered by the bench in the engine's place
   task automatic run_chan(input logic [7:0] hi, input slhcp_pkg::slhcp_kind_t kind,
                           input logic [7:0] mask, input logic [7:0] st);
      int s0;
      s0 = stopSeen;
      wr(slhcp_pkg::REG_CMD_IDX, {1'b0, 15'h2ABC, hi, mask});
      wait_req();
      `CHK("chanKind", kind, chanKind)
      `CHK("chanMask", mask, chanMask)
      rd(slhcp_pkg::REG_CMD_IDX, rv);
      `CHK("cmd busy", {16'h0, hi, mask}, rv)
      wr(slhcp_pkg::REG_CMD_IDX, 32'h8000_0800);
      `CHK("req kept", 1'b1, chanReq)
      // a taken stop would pulse one edge later, so look after that edge
      @(negedge sys_clk);
      `CHK("flagged stop", s0, stopSeen)
      chanDone = 1'b1;
      chanStatus = st;
      @(negedge sys_clk);
      chanDone = 1'b0;
      chanStatus = 8'($random(seed));
      wait_idle();
      `CHK("req dropped", 1'b0, chanReq)
      // model of started channels: start and setup add, stop removes
      case (kind)
         slhcp_pkg::KIND_START, slhcp_pkg::KIND_SETUP: begin
            mdlAct = mdlAct | (mask & ~st);
         end
         slhcp_pkg::KIND_STOP: begin
            mdlAct = mdlAct & ~mask;
         end
         default: begin
         end
      endcase
      `CHK("active", mdlAct, activeMask)
      mdlData = st;
      rd(slhcp_pkg::REG_DATA_IDX, rv);
      `CHK("status byte", {24'h0, mdlData}, rv)
   endtask : run_chan

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] m;
      logic [7:0] st;
      logic [7:0] actM;
      logic [7:0] a;
      int i;
      int hiCnt;
      int s0;
      repeat (3) @(negedge sys_clk);
      srst = 1'b0;
      rd(slhcp_pkg::REG_CMD_IDX, rv);
      `CHK("cmd reset", 32'h0, rv)
      rd(slhcp_pkg::REG_DATA_IDX, rv);
      `CHK("data reset", 32'h0, rv)
      wr(slhcp_pkg::REG_DATA_IDX, 32'hFFFF_FF5A);
      rd(slhcp_pkg::REG_DATA_IDX, rv);
      `CHK("data width", 32'h0000_005A, rv)
      wr(slhcp_pkg::REG_CMD_IDX, 32'h8000_1003);
      rd(slhcp_pkg::REG_CMD_IDX, rv);
      `CHK("flagged idle", 32'h0, rv)
      `CHK("no req", 1'b0, chanReq)
      $display("test registers done");
      // every channel command kind, start first so later masks hit live channels
      actM = 8'h01;
      for (i = 0; i < 4; i++) begin
         m = 8'($random(seed)) | 8'h01;
         st = 8'($random(seed)) & 8'hFE;
         if (kindTab[i] == slhcp_pkg::KIND_SYNC) m = actM;
         run_chan(hiTab[i], kindTab[i], m, st);
         if (i == 0) actM = m & ~st;
      end
      $display("test channel commands done");
      // stop-all while a start is still pending
      wr(slhcp_pkg::REG_CMD_IDX, 32'h0000_0903);
      wait_req();
      s0 = stopSeen;
      wr(slhcp_pkg::REG_CMD_IDX, 32'h0000_0800);
      @(negedge sys_clk);
      `CHK("stop pulse", s0 + 1, stopSeen)
      `CHK("stop req", 1'b0, chanReq)
      `CHK("stop active", 8'h00, activeMask)
      wait_idle();
      rd(slhcp_pkg::REG_DATA_IDX, rv);
      `CHK("data kept", {24'h0, mdlData}, rv)
      $display("test stop all done");
      // fixed local parameters
      loc_rd(8'h01, 8'h08);
      loc_rd(8'h04, 8'h00);
      loc_rd(8'h05, 8'h00);
      loc_rd(8'h07, CHAN_CNT);
      // writable local parameters, random places and bytes
      for (i = 0; i < 5; i++) begin
         a = 8'(8 + ($unsigned($random(seed)) % 248));
         st = 8'($random(seed));
         wait_idle();
         wr(slhcp_pkg::REG_DATA_IDX, {$random(seed)} & 32'h7FFF_FF00 | st);
         wr(slhcp_pkg::REG_CMD_IDX, 32'hA000 | a);
         mdlMem[a] = st;
      end
      foreach (mdlMem[k]) loc_rd(8'(k), mdlMem[k]);
      $display("test local parameters done");
      // processor reset command
      wait_idle();
      wr(slhcp_pkg::REG_CMD_IDX, 32'h0000_4000);
      hiCnt = 0;
      for (i = 0; i < 60; i++) begin
         @(negedge sys_clk);
         if (procReset === 1'b1) hiCnt++;
      end
      `CHK("proc reset long", 1'b1, hiCnt >= slhcp_pkg::PROC_RESET_CYC - 2)
      `CHK("proc reset short", 1'b1, hiCnt <= slhcp_pkg::PROC_RESET_CYC + 2)
      wait_idle();
      $display("test processor reset done");
      report_and_stop();
   end

   // watchdog: the whole sequence needs a few hundred cycles
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end

endmodule : serial_link_host_command_port_tb_top
